/* rtl/smad_datapath.v */
// Accumulator datapath with unsigned and signed arithmetic modes
`timescale 1ns/100ps
`include "smad_regs.vh"
`default_nettype none
module smad_datapath #(
  parameter IDX_W = `SMAD_IDX_W,
  parameter ACC_W = `SMAD_ACC_W,
  parameter IMM_W = `SMAD_IMM_W
) (
  input wire ref_clk,
  input wire rst_n,
  input wire opValid,
  input wire [`SMAD_OP_W-1:0] opCode,
  input wire [IMM_W-1:0] immValue,
  input wire [IDX_W-1:0] memData,
  // Registered outputs; each moves one edge after its op
  output reg signedMode,
  output reg [ACC_W-1:0] accum,
  output reg [ACC_W-1:0] secondAccum,
  output reg [IDX_W-1:0] indexReg
);
  // ----------------------------------------------------------------
  // Operand widening
  // ----------------------------------------------------------------
  // A mode op takes effect at its own edge, so the fill seen by an
  // operation is always the mode left by the op before it
  wire [ACC_W-1:0] wideIndex;
  wire [ACC_W-1:0] wideMem;
  wire [ACC_W-1:0] wideImm;
  wire [ACC_W-1:0] wideImmByte;
  wire [ACC_W-1:0] wideSecond;

  smad_widen #(.IN_W(IDX_W), .OUT_W(ACC_W)) uIdx (
    .narrow(indexReg),
    .signedMode(signedMode),
    .wide(wideIndex)
  );

  smad_widen #(.IN_W(IDX_W), .OUT_W(ACC_W)) uMem (
    .narrow(memData),
    .signedMode(signedMode),
    .wide(wideMem)
  );

  smad_widen #(.IN_W(IMM_W), .OUT_W(ACC_W)) uImm (
    .narrow(immValue),
    .signedMode(signedMode),
    .wide(wideImm)
  );

  smad_widen #(.IN_W(IDX_W), .OUT_W(ACC_W)) uImmB (
    .narrow(immValue[IDX_W-1:0]),
    .signedMode(signedMode),
    .wide(wideImmByte)
  );

  smad_widen #(.IN_W(IDX_W), .OUT_W(ACC_W)) uSwap (
    .narrow(indexReg),
    .signedMode(signedMode),
    .wide(wideSecond)
  );

  // ----------------------------------------------------------------
  // Fractional multiply
  // ----------------------------------------------------------------
  // Multiply ignores the mode: both operands are always signed fractions
  // An 8 x 14 product needs 22 bits before truncation
  wire signed [ACC_W-1:0] accumFrac;
  wire signed [IDX_W-1:0] memFrac;
  wire signed [ACC_W+IDX_W-1:0] product;
  wire [ACC_W-1:0] mulResult;
  assign accumFrac = accum;
  assign memFrac = memData;
  assign product = accumFrac * memFrac;
  // drop low 8 bits, keep upper 14
  assign mulResult = product[ACC_W+IDX_W-1:IDX_W];

  // ----------------------------------------------------------------
  // Next-state selection
  // ----------------------------------------------------------------
  // One process per register keeps each next value in one place;
  // a refused op (opValid low or a spare code) keeps every register
  reg next_signedMode;
  reg [ACC_W-1:0] next_accum;
  reg [ACC_W-1:0] next_secondAccum;
  reg [IDX_W-1:0] next_indexReg;

  // Mode bit: only the two mode opcodes move it
  always @* begin
    next_signedMode = signedMode;
    if (opValid) begin
      case (opCode)
        `SMAD_OP_SIGNED: next_signedMode = 1'b1;
        `SMAD_OP_UNSIGNED: next_signedMode = 1'b0;
        // Every other opcode keeps the mode
        default: next_signedMode = signedMode;
      endcase
    end
  end

  // Accumulator: loads, adds, subtract and multiply
  always @* begin
    next_accum = accum;
    if (opValid) begin
      case (opCode)
        // index copy, zero or sign fill
        `SMAD_OP_COPYIDX: next_accum = wideIndex;
        `SMAD_OP_ADDIMM: next_accum = accum + wideImm;
        `SMAD_OP_ADDMEM: next_accum = accum + wideMem;
        `SMAD_OP_SUBMEM: next_accum = accum - wideMem;
        `SMAD_OP_LUA: next_accum = wideMem;
        `SMAD_OP_LDIMM: next_accum = wideImmByte;
        `SMAD_OP_LDMEM: next_accum = wideMem;
        `SMAD_OP_MUL: next_accum = mulResult;
        // Other opcodes keep it
        default: next_accum = accum;
      endcase
    end
  end

  // Secondary accumulator: lookup and exchange;
  // the exchange reads the old index before it is replaced
  always @* begin
    next_secondAccum = secondAccum;
    if (opValid) begin
      case (opCode)
        `SMAD_OP_LUB: next_secondAccum = wideMem;
        `SMAD_OP_SWAPBX: next_secondAccum = wideSecond;
        // Other opcodes keep it
        default: next_secondAccum = secondAccum;
      endcase
    end
  end

  // Index register: direct load and exchange
  always @* begin
    next_indexReg = indexReg;
    if (opValid) begin
      case (opCode)
        `SMAD_OP_SWAPBX: next_indexReg = secondAccum[IDX_W-1:0];
        // Index load from the memory byte
        `SMAD_OP_LDIDX: next_indexReg = memData;
        // Other opcodes keep it
        default: next_indexReg = indexReg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // Reset is synchronous and wins over an op on the same edge
  // unsigned after reset
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      signedMode <= `SMAD_MODE_RESET;
    end else begin
      signedMode <= next_signedMode;
    end
  end

  // Accumulator register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      accum <= `SMAD_ACC_RESET;
    end else begin
      accum <= next_accum;
    end
  end

  // Secondary accumulator register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      secondAccum <= `SMAD_ACC_RESET;
    end else begin
      secondAccum <= next_secondAccum;
    end
  end

  // Index register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      indexReg <= `SMAD_IDX_RESET;
    end else begin
      indexReg <= next_indexReg;
    end
  end
endmodule
`default_nettype wire

/* rtl/smad_regs.vh */
// Constants of the sign-mode accumulator datapath
`ifndef SMAD_REGS_VH
`define SMAD_REGS_VH
`define SMAD_IDX_W 8
`define SMAD_ACC_W 14
`define SMAD_IMM_W 12
`define SMAD_MODE_RESET 1'b0
`define SMAD_ACC_RESET 14'h0000
`define SMAD_IDX_RESET 8'h00
`define SMAD_OP_W 4
`define SMAD_OP_NOP 4'h0
`define SMAD_OP_SIGNED 4'h1
`define SMAD_OP_UNSIGNED 4'h2
`define SMAD_OP_COPYIDX 4'h3
`define SMAD_OP_ADDIMM 4'h4
`define SMAD_OP_ADDMEM 4'h5
`define SMAD_OP_SUBMEM 4'h6
`define SMAD_OP_LUA 4'h7
`define SMAD_OP_LUB 4'h8
`define SMAD_OP_LDIMM 4'h9
`define SMAD_OP_LDMEM 4'hA
`define SMAD_OP_SWAPBX 4'hB
`define SMAD_OP_MUL 4'hC
`define SMAD_OP_LDIDX 4'hD
`endif

/* rtl/smad_widen.v */
// Mode-dependent widening of a narrow operand
`timescale 1ns/100ps
`default_nettype none
module smad_widen #(
  parameter IN_W = 8,
  parameter OUT_W = 14
) (
  input wire [IN_W-1:0] narrow,
  input wire signedMode,
  output wire [OUT_W-1:0] wide
);
  // Fill upper bits with sign bit or zero
  assign wide = {{(OUT_W-IN_W){signedMode & narrow[IN_W-1]}}, narrow};
endmodule
`default_nettype wire

/* sim/smad_checker.sv */
// Port assertions for the accumulator datapath
`timescale 1ns/100ps
`default_nettype none
module smad_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic signedMode,
  input wire logic [3:0] opCode,
  input wire logic [11:0] immValue,
  input wire logic [7:0] memData,
  input wire logic [7:0] indexReg,
  input wire logic [13:0] accum,
  input wire logic [13:0] secondAccum
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Accepted op decode and widened operands
  wire logic [15:0] go = 16'(opValid) << opCode;
  wire logic [13:0] xw = {{6{signedMode & indexReg[7]}}, indexReg};
  wire logic [13:0] mw = {{6{signedMode & memData[7]}}, memData};
  wire logic [13:0] ai = accum + {{2{signedMode & immValue[11]}}, immValue};
  wire logic [13:0] sm = accum - mw;
  wire logic signed [21:0] pr = $signed(accum) * $signed(memData);
  a_reset_unsigned: assert property ($rose(rst_n) |-> !signedMode)
    else $error("mode");
  a_mode_set: assert property (go[1] |=> signedMode)
    else $error("set");
  a_mode_clear: assert property (go[2] |=> !signedMode)
    else $error("clr");
  a_copy_widen: assert property (go[3] |=> accum == $past(xw))
    else $error("copy");
  a_add_imm: assert property (go[4] |=> accum == $past(ai))
    else $error("addi");
  a_sub_mem: assert property (go[6] |=> accum == $past(sm))
    else $error("sub");
  a_mul_frac: assert property (
    go[12] |=> accum == $past(pr[21:8])) else $error("mul");
  a_swap_regs: assert property (go[11] |=> secondAccum == $past(xw)
    && indexReg == 8'($past(secondAccum))) else $error("swap");
  c_signed_copy: cover property (go[1] ##1 go[3]);
  c_add_imm: cover property (go[4]);
  c_mul: cover property (go[12]);
  c_swap: cover property (go[11]);
endmodule
`default_nettype wire

/* sim/smad_seq_model.sv */
// Sequencer model issuing one operation strobe per request
`timescale 1ns/100ps
`default_nettype none
module smad_seq_model (
  input wire logic ref_clk,
  input wire logic req,
  input wire logic [23:0] rw,
  output logic opValid,
  output logic [3:0] opCode,
  output logic [11:0] immValue,
  output logic [7:0] memData
);
  initial {opValid, opCode, immValue, memData} = '0;
  // Operand lines toggle while no op is offered
  always @(posedge ref_clk) begin
    opValid <= req;
    {opCode, immValue, memData} <= req ? rw : ~{opCode, immValue, memData};
  end
endmodule
`default_nettype wire

/* sim/test_smad_datapath.sv */
// Random and corner tests of the accumulator datapath
`timescale 1ns/100ps
`default_nettype none
module test_smad_datapath;
  logic ref_clk = 0, rst_n = 0, req = 0, opValid, signedMode, eM;
  logic [23:0] rw = '0;
  logic [3:0] opCode;
  logic [11:0] immValue;
  logic [7:0] memData, indexReg, eX;
  logic [13:0] accum, secondAccum, eA, eB;
  logic signed [21:0] p;
  int errors = 0, n_checks = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  smad_seq_model u_smad_seq_model (.ref_clk, .req, .rw, .opValid, .opCode,
    .immValue, .memData);
  smad_datapath u_smad_datapath (.ref_clk, .rst_n, .opValid, .opCode,
    .immValue, .memData, .signedMode, .accum, .secondAccum, .indexReg);
  // Widen a value of width w by the expected mode
  function automatic logic [13:0] wid(input logic [11:0] v, input int w);
    wid = v & ~(14'h3FFF << w);
    if (eM && v[w-1])
      wid = wid | (14'h3FFF << w);
  endfunction
  // Issue one op and update the expected state
  task automatic op(input logic [3:0] c, input logic [11:0] i, m);
    p = $signed(eA) * $signed(m[7:0]);
    @(posedge ref_clk);
    req <= 1'b1;
    rw <= {c, i, m[7:0]};
    case (c)
      4'h1: eM = 1'b1;
      4'h2: eM = 1'b0;
      4'h3: eA = wid(eX, 8);
      4'h4: eA = eA + wid(i, 12);
      4'h5: eA = eA + wid(m, 8);
      4'h6: eA = eA - wid(m, 8);
      4'h7, 4'hA: eA = wid(m, 8);
      4'h8: eB = wid(m, 8);
      4'h9: eA = wid(i[7:0], 8);
      4'hB: {eB, eX} = {wid(eX, 8), eB[7:0]};
      4'hC: eA = p[21:8];
      4'hD: eX = m[7:0];
      default: ;
    endcase
  endtask
  task automatic cmp(input string n, input logic [13:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Drain the pipe then compare all outputs
  task automatic chk();
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp("mode", 14'(eM), 14'(signedMode));
    cmp("accum", eA, accum);
    cmp("second", eB, secondAccum);
    cmp("index", 14'(eX), 14'(indexReg));
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (++cyc > 5000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h067541F0));
    {eM, eA, eB, eX} = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk();
    op(4'hD, 12'h000, 12'h0FF);
    op(4'h3, 12'h000, 12'h000);
    chk();
    op(4'h1, 12'h000, 12'h000);
    op(4'h3, 12'h000, 12'h000);
    op(4'h4, 12'hFFF, 12'h000);
    chk();
    op(4'h2, 12'h000, 12'h000);
    op(4'h4, 12'hFFF, 12'h000);
    op(4'hC, 12'h000, 12'h080);
    chk();
    for (int k = 0; k < 400; k++) begin
      op(4'($urandom), 12'($urandom), 12'($urandom));
      if (k % 8 == 7)
        chk();
      if (k == 200) begin
        chk();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        {eM, eA, eB, eX} = '0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk();
      end
    end
    chk();
    close_out();
  end
endmodule
bind smad_datapath smad_checker u_smad_checker (.ref_clk, .rst_n, .opValid,
  .signedMode, .opCode, .immValue, .memData, .indexReg, .accum, .secondAccum);
`default_nettype wire
